// >>> rtl/cfrs_pkg.sv
// Types shared by the config and reference source select block.
// Assumes cfrs_regs.svh supplies all numeric constants.
package cfrs_pkg;

  // Phase of the two-wire target port
  typedef enum logic [2:0] {
    CFRS_TW_IDLE,
    CFRS_TW_ADDR,
    CFRS_TW_REG,
    CFRS_TW_WDATA,
    CFRS_TW_RDATA
  } cfrs_tw_e;

endpackage

// >>> rtl/cfrs_regs.svh
// Register offsets, field positions, reset values and timing for the
// config and reference source select block. Assumes a 40 MHz ref_clk.
`ifndef CFRS_REGS_SVH
`define CFRS_REGS_SVH

// Register offsets on the two-wire target port
`define CFRS_OFS_TRIM 8'h12
`define CFRS_OFS_PRIM_SRC 8'h13
`define CFRS_OFS_SPREAD 8'h14

// Field positions in the primary source register
`define CFRS_BIT_PRIM_SRC 1
`define CFRS_SWO_MODE_HI 7
`define CFRS_SWO_MODE_LO 6
// Field positions in the spread register
`define CFRS_BIT_SPR_EN 7
`define CFRS_BIT_SPR_DOWN 6
`define CFRS_SPR_AMT_HI 5

// Reset values
`define CFRS_RST_PRIM_SRC 8'h00
`define CFRS_RST_TRIM 6'h00
`define CFRS_RST_SPREAD 8'h00

// Spread amount limits, code is in 0.25 percent steps
`define CFRS_SPR_CTR_MIN 6'h01
`define CFRS_SPR_CTR_MAX 6'h0a
`define CFRS_SPR_DN_MIN 6'h02
`define CFRS_SPR_DN_MAX 6'h14

// Timing
`define CFRS_CLK_HZ 40000000
`define CFRS_SEL_SKEW_NS 100
`define CFRS_SEL_STABLE_US 1000
`define CFRS_STRAP_WAIT 2'h3

// Two-wire bit counter figures
`define CFRS_LAST_BIT 4'h7
`define CFRS_ACK_BIT 4'h8
// Parked one below zero after a start, so the start's own clock fall lands on zero
`define CFRS_START_BIT 4'hf

`endif

// >>> rtl/cfrs_top.sv
// Config select, reference source select, crystal trim and spread
// settings, with the strap-selected two-wire target port.
// Assumes all pins are asynchronous to ref_clk and reset_n is the
// internal power-up reset, synchronous to ref_clk.
`include "cfrs_regs.svh"

// How it works
// - The strap pin level is sampled at power-up and kept to decide what the shared pins do.
// - A high strap makes the two shared pins the high and low config select inputs.
// - A low or floating strap makes the two shared pins the data and clock of the target port.
// - After power-up the strap pin stops being an input and drives the reference clock out.
// - The config loaded is the two-bit number formed by the high and low select pins.
// - The primary source bit makes the crystal input primary at 0 and the diff input at 1.
// - In manual mode the crystal input is active when the select pin equals primary bit.
// - The primary source bit is bit 1 of the register at 0x13, writable over the port.
// - Pin selection acts only while the upper switchover mode bit is clear.
// - A 6-bit trim code sets load capacitance to 4.5 pF plus half the code.
// - Spread is held in one register for the block: centre 0.25 to 2.5 percent, down 0.5 to 5 percent.
// - A change of reference is handed out as one clean registered select.
module cfrs_top #(
  parameter logic [6:0] TARGET_ADDR = 7'h55, // Arbitrary value
  parameter int SEL_STABLE_CYC = (`CFRS_CLK_HZ / 1000000) * `CFRS_SEL_STABLE_US
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ref_out_strap_pin,
  output logic ref_clock_output,
  output logic ref_out_oe,
  input wire logic cfg_hi_sda_pin,
  output logic sda_out,
  output logic sda_oe,
  input wire logic cfg_lo_scl_pin,
  input wire logic input_select_pin,
  output logic i2c_mode,
  output logic [1:0] active_config,
  output logic config_load,
  output logic ref_sel_diff,
  output logic [5:0] crystal_load_trim,
  output logic spread_enable,
  output logic spread_down,
  output logic [5:0] spread_amount
);

  // Settle time after the last select pin edge, rounded up
  localparam int SKEW_CYC = (`CFRS_SEL_SKEW_NS * (`CFRS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int SEL_CNT_W = $clog2(SEL_STABLE_CYC + SKEW_CYC + 1);
  localparam logic [SEL_CNT_W-1:0] SEL_DONE = SEL_CNT_W'(SEL_STABLE_CYC + SKEW_CYC);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] strap_sync_r, hi_sync_r, lo_sync_r, csel_sync_r;
  logic hi_d_r, lo_d_r;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge ref_clk) begin
    strap_sync_r <= {strap_sync_r[0], ref_out_strap_pin};
    hi_sync_r <= {hi_sync_r[0], cfg_hi_sda_pin};
    lo_sync_r <= {lo_sync_r[0], cfg_lo_scl_pin};
    csel_sync_r <= {csel_sync_r[0], input_select_pin};
    hi_d_r <= hi_sync_r[1];
    lo_d_r <= lo_sync_r[1];
    sda_out <= 1'b0; // Open drain: the pin is only ever pulled low
  end

  // ----------------------------------------------------------------
  // Strap capture and reference output
  // ----------------------------------------------------------------
  logic [1:0] strap_wait_r;
  logic strap_done_r, strap_hi_r, ref_div_r;

  // Wait for the synchroniser to fill before catching the strap once
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_hi_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_wait_r == `CFRS_STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        strap_hi_r <= strap_sync_r[1];
      end else begin
        strap_wait_r <= strap_wait_r + 2'h1;
      end
    end
  end

  // Pin turns into a driven reference output once the strap is held
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ref_out_oe <= 1'b0;
      ref_div_r <= 1'b0;
      ref_clock_output <= 1'b0;
      i2c_mode <= 1'b0;
    end else begin
      ref_out_oe <= strap_done_r;
      ref_div_r <= strap_done_r ? ~ref_div_r : 1'b0;
      ref_clock_output <= ref_div_r;
      i2c_mode <= strap_done_r & ~strap_hi_r;
    end
  end

  // ----------------------------------------------------------------
  // Hardware config select
  // ----------------------------------------------------------------
  logic [SEL_CNT_W-1:0] sel_cnt_r;

  // Reload only after both pins have held still; a skewed pair of
  // edges restarts the wait so no half-changed index is loaded.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sel_cnt_r <= '0;
      active_config <= 2'h0;
      config_load <= 1'b0;
    end else begin
      config_load <= 1'b0;
      if (!strap_done_r || !strap_hi_r) begin
        sel_cnt_r <= '0;
      end else if (hi_sync_r[1] != hi_d_r || lo_sync_r[1] != lo_d_r) begin
        sel_cnt_r <= '0;
      end else if (sel_cnt_r != SEL_DONE) begin
        sel_cnt_r <= sel_cnt_r + 1'b1;
        if (sel_cnt_r == SEL_DONE - 1'b1) begin
          active_config <= {hi_sync_r[1], lo_sync_r[1]};
          config_load <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] prim_src_r, spread_r, reg_ptr_r, wr_data, rd_data;
  logic wr_en;

  // Write side, fed by the target port
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prim_src_r <= `CFRS_RST_PRIM_SRC;
      crystal_load_trim <= `CFRS_RST_TRIM;
      spread_r <= `CFRS_RST_SPREAD;
    end else if (wr_en) begin
      if (reg_ptr_r == `CFRS_OFS_PRIM_SRC) begin
        prim_src_r <= wr_data;
      end else if (reg_ptr_r == `CFRS_OFS_TRIM) begin
        crystal_load_trim <= wr_data[5:0];
      end else if (reg_ptr_r == `CFRS_OFS_SPREAD) begin
        spread_r <= wr_data;
      end
    end
  end

  // Read side; unmapped offsets read zero
  always_comb begin
    if (reg_ptr_r == `CFRS_OFS_PRIM_SRC) begin
      rd_data = prim_src_r;
    end else if (reg_ptr_r == `CFRS_OFS_TRIM) begin
      rd_data = {2'h0, crystal_load_trim};
    end else if (reg_ptr_r == `CFRS_OFS_SPREAD) begin
      rd_data = spread_r;
    end else begin
      rd_data = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Reference select and spread outputs
  // ----------------------------------------------------------------
  logic [5:0] spr_amt;
  logic spr_dn;

  assign spr_amt = spread_r[`CFRS_SPR_AMT_HI:0];
  assign spr_dn = spread_r[`CFRS_BIT_SPR_DOWN];

  // One registered select: downstream mux sees a single clean change
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ref_sel_diff <= 1'b0;
    end else if (!prim_src_r[`CFRS_SWO_MODE_HI]) begin
      ref_sel_diff <= csel_sync_r[1] ^ prim_src_r[`CFRS_BIT_PRIM_SRC];
    end else begin
      ref_sel_diff <= prim_src_r[`CFRS_BIT_PRIM_SRC];
    end
  end

  // Spread amount held inside the legal range of its mode
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      spread_enable <= 1'b0;
      spread_down <= 1'b0;
      spread_amount <= `CFRS_SPR_CTR_MIN;
    end else begin
      spread_enable <= spread_r[`CFRS_BIT_SPR_EN];
      spread_down <= spr_dn;
      if (spr_dn) begin
        spread_amount <= (spr_amt < `CFRS_SPR_DN_MIN) ? `CFRS_SPR_DN_MIN :
                         (spr_amt > `CFRS_SPR_DN_MAX) ? `CFRS_SPR_DN_MAX : spr_amt;
      end else begin
        spread_amount <= (spr_amt < `CFRS_SPR_CTR_MIN) ? `CFRS_SPR_CTR_MIN :
                         (spr_amt > `CFRS_SPR_CTR_MAX) ? `CFRS_SPR_CTR_MAX : spr_amt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-wire target port
  // ----------------------------------------------------------------
  cfrs_pkg::cfrs_tw_e tw_state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_r, tx_r;
  logic scl_rise, scl_fall, bus_start, bus_stop, host_ack_r;

  assign scl_rise = lo_sync_r[1] & ~lo_d_r;
  assign scl_fall = ~lo_sync_r[1] & lo_d_r;
  assign bus_start = lo_sync_r[1] & lo_d_r & hi_d_r & ~hi_sync_r[1];
  assign bus_stop = lo_sync_r[1] & lo_d_r & ~hi_d_r & hi_sync_r[1];
  assign wr_en = i2c_mode && scl_fall && tw_state_r == cfrs_pkg::CFRS_TW_WDATA &&
                 bit_cnt_r == `CFRS_LAST_BIT;
  assign wr_data = rx_r;

  // Byte engine; the pointer auto-increments after each written data byte, not after a read byte
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !i2c_mode) begin
      tw_state_r <= cfrs_pkg::CFRS_TW_IDLE;
      bit_cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe <= 1'b0;
      host_ack_r <= 1'b0;
      reg_ptr_r <= 8'h00;
    end else if (bus_start) begin
      tw_state_r <= cfrs_pkg::CFRS_TW_ADDR;
      bit_cnt_r <= `CFRS_START_BIT; // Start's own clock fall must not count as a bit
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      tw_state_r <= cfrs_pkg::CFRS_TW_IDLE;
      sda_oe <= 1'b0;
    end else if (tw_state_r != cfrs_pkg::CFRS_TW_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_r != `CFRS_ACK_BIT) begin
          rx_r <= {rx_r[6:0], hi_sync_r[1]};
        end else begin
          host_ack_r <= ~hi_sync_r[1];
        end
      end else if (scl_fall) begin
        if (bit_cnt_r == `CFRS_LAST_BIT) begin
          bit_cnt_r <= `CFRS_ACK_BIT;
          if (tw_state_r == cfrs_pkg::CFRS_TW_RDATA) begin
            sda_oe <= 1'b0;
          end else if (tw_state_r == cfrs_pkg::CFRS_TW_ADDR && rx_r[7:1] != TARGET_ADDR) begin
            tw_state_r <= cfrs_pkg::CFRS_TW_IDLE;
          end else begin
            sda_oe <= 1'b1;
            if (tw_state_r == cfrs_pkg::CFRS_TW_REG) begin
              reg_ptr_r <= rx_r;
            end else if (tw_state_r == cfrs_pkg::CFRS_TW_WDATA) begin
              reg_ptr_r <= reg_ptr_r + 8'h01;
            end
          end
        end else if (bit_cnt_r == `CFRS_ACK_BIT) begin
          bit_cnt_r <= 4'h0;
          sda_oe <= 1'b0;
          case (tw_state_r)
            cfrs_pkg::CFRS_TW_ADDR: begin
              if (rx_r[0]) begin
                tw_state_r <= cfrs_pkg::CFRS_TW_RDATA;
                tx_r <= rd_data;
                sda_oe <= ~rd_data[7];
              end else begin
                tw_state_r <= cfrs_pkg::CFRS_TW_REG;
              end
            end
            cfrs_pkg::CFRS_TW_REG: tw_state_r <= cfrs_pkg::CFRS_TW_WDATA;
            cfrs_pkg::CFRS_TW_RDATA: begin
              if (host_ack_r) begin
                tx_r <= rd_data;
                sda_oe <= ~rd_data[7];
              end else begin
                tw_state_r <= cfrs_pkg::CFRS_TW_IDLE;
              end
            end
            default: tw_state_r <= tw_state_r;
          endcase
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (tw_state_r == cfrs_pkg::CFRS_TW_RDATA) begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe <= ~tx_r[6];
          end
        end
      end
    end
  end

endmodule

// >>> tb/cfrs_assertions.sv
// Port checker for the config and reference source select block.
// Assumes one clock domain; bound into cfrs_top below.
module cfrs_chk #(
  parameter int SEL_STABLE_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ref_clock_output,
  input wire logic ref_out_oe,
  input wire logic cfg_hi_sda_pin,
  input wire logic cfg_lo_scl_pin,
  input wire logic sda_oe,
  input wire logic i2c_mode,
  input wire logic [1:0] active_config,
  input wire logic config_load,
  input wire logic [5:0] crystal_load_trim
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] still_r;

  // Cycles the select pin pair has held still; saturates
  always_ff @(posedge ref_clk) begin
    if (!reset_n || $changed({cfg_hi_sda_pin, cfg_lo_scl_pin})) begin
      still_r <= 16'h0000;
    end else if (still_r != 16'hffff) begin
      still_r <= still_r + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_mode_needs_strap: assert property (i2c_mode |-> ref_out_oe)
    else $error("port mode set before strap capture");
  a_mode_held: assert property (ref_out_oe && $past(ref_out_oe) |-> $stable(i2c_mode))
    else $error("pin function changed after capture");
  a_oe_sticky: assert property (ref_out_oe |=> ref_out_oe)
    else $error("reference output released");
  a_ref_quiet: assert property (!ref_out_oe |-> !ref_clock_output)
    else $error("reference output toggles before capture");
  a_ref_runs: assert property (ref_out_oe [*3] |=> ref_clock_output != $past(ref_clock_output))
    else $error("reference output stuck");
  a_sel_no_sda: assert property (!i2c_mode |-> !sda_oe)
    else $error("data line pulled in select mode");
  a_sel_trim_dead: assert property (!i2c_mode && ref_out_oe |-> $stable(crystal_load_trim))
    else $error("trim changed with port disabled");
  a_load_pulse: assert property (config_load |=> !config_load)
    else $error("config load longer than one cycle");
  a_load_wait: assert property (config_load |-> 32'(still_r) >= SEL_STABLE_CYC)
    else $error("config loaded before pins settled");
  a_load_value: assert property (config_load |-> active_config == {cfg_hi_sda_pin, cfg_lo_scl_pin})
    else $error("loaded config differs from pins");
endmodule

bind cfrs_top cfrs_chk #(.SEL_STABLE_CYC(SEL_STABLE_CYC)) chk_i (
  .ref_clk, .reset_n, .ref_clock_output, .ref_out_oe, .cfg_hi_sda_pin, .cfg_lo_scl_pin,
  .sda_oe, .i2c_mode, .active_config, .config_load, .crystal_load_trim
);

// >>> tb/cfrs_board.sv
// Board side model: strap resistor, select levels and open-drain data line.
// Assumes the host drives the clock and pulls data low only.
module cfrs_board (
  input wire logic strap_lvl,
  input wire logic config_select_hi,
  input wire logic config_select_lo,
  input wire logic host_sda_low,
  input wire logic host_scl,
  input wire logic ref_out_oe,
  input wire logic ref_clock_output,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic i2c_mode,
  output logic ref_out_strap_pin,
  output logic cfg_hi_sda_pin,
  output logic cfg_lo_scl_pin,
  output logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Resistor level until the device takes the pin over
  assign ref_out_strap_pin = ref_out_oe ? ref_clock_output : strap_lvl;
  // Pull-up, either party may pull low
  assign sda_line = !((sda_oe && !sda_out) || host_sda_low);
  // Select pins move as a pair, straight through
  assign cfg_hi_sda_pin = i2c_mode ? sda_line : config_select_hi;
  assign cfg_lo_scl_pin = i2c_mode ? host_scl : config_select_lo;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for cfrs_top with a bit-banged two-wire host.
// Assumes cfrs_board models the pins; inputs change on falling edges.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h55; // Arbitrary value
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap_lvl = 1'b0, config_select_hi = 1'b0, config_select_lo = 1'b0;
  logic host_sda_low = 1'b0, host_scl = 1'b1, input_select_pin = 1'b0;
  logic ref_out_strap_pin, cfg_hi_sda_pin, cfg_lo_scl_pin, sda_line, sda_out, sda_oe;
  logic ref_clock_output, ref_out_oe, i2c_mode, config_load, ref_sel_diff;
  logic spread_enable, spread_down;
  logic [1:0] active_config;
  logic [5:0] crystal_load_trim, spread_amount;
  logic [7:0] v;
  logic [1:0] order [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic [7:0] spr [4] = '{8'hd4, 8'hd4, 8'h94, 8'h8a};
  int failures = 0, check_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  cfrs_top #(.TARGET_ADDR(ADDR), .SEL_STABLE_CYC(20)) dut (.ref_clk, .reset_n,
    .ref_out_strap_pin, .ref_clock_output, .ref_out_oe, .cfg_hi_sda_pin, .sda_out,
    .sda_oe, .cfg_lo_scl_pin, .input_select_pin, .i2c_mode, .active_config,
    .config_load, .ref_sel_diff, .crystal_load_trim, .spread_enable, .spread_down,
    .spread_amount);
  cfrs_board board (.strap_lvl, .config_select_hi, .config_select_lo, .host_sda_low,
    .host_scl, .ref_out_oe, .ref_clock_output, .sda_oe, .sda_out, .i2c_mode, .ref_out_strap_pin,
    .cfg_hi_sda_pin, .cfg_lo_scl_pin, .sda_line);

  // ----------------------------------------
  // Host tasks
  // ----------------------------------------
  task automatic test_done();
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Data moves a cycle after clock falls so no false start or stop is seen
  task automatic tw_bit(input logic b, output logic r);
    tick(1);
    host_sda_low = !b;
    tick(3);
    host_scl = 1'b1;
    tick(4);
    r = sda_line;
    host_scl = 1'b0;
  endtask
  // Also serves as repeated start; waits out the device's ack release
  task automatic tw_start();
    tick(1);
    host_sda_low = 1'b0;
    tick(4);
    host_scl = 1'b1;
    tick(4);
    host_sda_low = 1'b1;
    tick(4);
    host_scl = 1'b0;
  endtask
  task automatic tw_stop();
    tick(1);
    host_sda_low = 1'b1;
    tick(4);
    host_scl = 1'b1;
    tick(4);
    host_sda_low = 1'b0;
    tick(4);
  endtask
  // Byte MSB first, host releases the ack slot
  task automatic tw_byte(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) tw_bit(d[i], q[i]);
    tw_bit(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    logic a, b, c;
    tw_start();
    tw_byte({ADDR, 1'b0}, q, a);
    tw_byte(p, q, b);
    tw_byte(d, q, c);
    tw_stop();
    chk("write acks", 8'h00, {5'h00, a, b, c});
  endtask
  // Pointer write, repeated start, one byte read, host nack
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic a;
    tw_start();
    tw_byte({ADDR, 1'b0}, q, a);
    tw_byte(p, q, a);
    tw_start();
    tw_byte({ADDR, 1'b1}, q, a);
    tw_byte(8'hff, d, a);
    tw_stop();
  endtask
  task automatic power_up(input logic s);
    reset_n = 1'b0;
    strap_lvl = s;
    tick(2);
    reset_n = 1'b1;
    for (int i = 0; i < 20 && !ref_out_oe; i++) tick(1);
    chk("strap mode", {7'h00, !s}, {7'h00, i2c_mode});
    if (ref_out_oe !== 1'b1) begin
      $display("wrong value ref_out_oe expected 1 seen %b", ref_out_oe);
      failures++;
      test_done();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    power_up(1'b0);
    strap_lvl = 1'b1;
    tick(10);
    chk("mode after strap move", 8'h01, {7'h00, i2c_mode});
    for (int k = 0; k < 4; k++) begin
      wr(8'h13, {6'h00, k[1], 1'b0});
      input_select_pin = k[0];
      tick(6);
      chk("ref select", {7'h00, k[0] ^ k[1]}, {7'h00, ref_sel_diff});
    end
    wr(8'h13, 8'h82);
    for (int k = 0; k < 2; k++) begin
      input_select_pin = k[0];
      tick(6);
      chk("pin select off", 8'h01, {7'h00, ref_sel_diff});
    end
    rd(8'h13, v);
    chk("reg 13 read", 8'h82, v);
    rd(8'h30, v);
    chk("unmapped read", 8'h00, v);
    for (int k = 0; k < 2; k++) begin
      wr(8'h12, k[0] ? 8'h0e : 8'h3f);
      chk("trim", k[0] ? 8'h0e : 8'h3f, {2'h0, crystal_load_trim});
    end
    // Down at its top code, then centre clamped to its top code
    for (int k = 0; k < 4; k += 2) begin
      wr(8'h14, spr[k]);
      chk("spread", spr[k + 1], {spread_enable, spread_down, spread_amount});
    end
    power_up(1'b1);
    tick(60);
    foreach (order[k]) begin
      {config_select_hi, config_select_lo} = order[k];
      for (int n = 0; n < 100 && !config_load; n++) tick(1);
      chk("config load", 8'h01, {7'h00, config_load});
      chk("config", {6'h00, order[k]}, {6'h00, active_config});
      tick(5);
    end
    test_done();
  end

  // Hang guard
  initial begin
    tick(90000);
    failures++;
    test_done();
  end
endmodule
